// File: burst_host_model.sv
/*
 host side of the burst link: makes the link clock and takes words.
 assumes the core drives wait and data on the link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_host_model (
   input wire logic i_en,
   input wire logic i_wait,
   input wire logic [nor_flash_pkg::WORD_W-1:0] i_data,
   output logic o_clk,
   output logic o_ack
);
   logic [1:0] ph_q = 2'h0;
   logic [nor_flash_pkg::WORD_W-1:0] got[$];
   // clock only while enabled, offset so it never lines up with the core clock
   initial
   begin
      o_clk = 1'b0;
      #1.7;
      forever #3 if (i_en) o_clk = ~o_clk;
   end
   always_ff @(posedge o_clk) ph_q <= ph_q + 2'h1;
   // stall one edge in four to exercise the hold
   assign o_ack = (ph_q != 2'h3);
   always @(posedge o_clk) if (o_ack && !i_wait) got.push_back(i_data);
endmodule : burst_host_model
`default_nettype wire

// File: nor_flash_operation_core.sv
/*
 gray-pointer async fifo and the nor flash operation core top.
 assumes the host drives commands and reads on i_ref_clk and pulls burst words on i_burst_clk.
*/
// Behaviour
// - after reset the read mode is asynchronous page read until configured otherwise.
// - burst reads run only once the read mode configuration selects synchronous mode.
// - burst words are presented aligned to the host supplied burst clock.
// - a wait output shows when no valid burst word is presented and the host honours it.
// - an erase clears every word of exactly one block and no other.
// - the array has small parameter blocks and larger main blocks.
// - top configuration puts parameter blocks at high addresses, bottom at low.
// - an internal sequencer times erase and program on its own once commanded.
// - a readable status register shows completion and errors.
// - an erase can be suspended so other blocks can be read or programmed, then resumed.
// - a program can be suspended so other words can be read, then resumed.
// - programming works on whole sixteen bit words.
// - all data moves over a sixteen bit bus.
// - each block locks and unlocks at once with no added latency.
// - an identity area returns a unique device identifier.
// - four predefined array regions can be made one time programmable.
`timescale 1ns/1ps
`default_nettype none
module flash_async_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic i_wr_clk,
   input wire logic i_wr_rst,
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_rd_clk,
   input wire logic i_rd_rst,
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wbin_q, rbin_q, wgray_q, rgray_q, wg_s1_q, wg_s2_q, rg_s1_q, rg_s2_q;
   logic [AW:0] wbin_d, rbin_d;
   logic do_wr, do_rd;
   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : bin2gray
   // full compares against the synced read pointer, so it may stay full a few cycles late
   assign o_wr_ready = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
   assign o_rd_valid = (rgray_q != wg_s2_q);
   assign o_rd_data = mem_q[rbin_q[AW-1:0]];
   assign do_wr = i_wr_valid && o_wr_ready;
   assign do_rd = o_rd_valid && i_rd_ready;
   assign wbin_d = wbin_q + (AW+1)'(do_wr);
   assign rbin_d = rbin_q + (AW+1)'(do_rd);
   always_ff @(posedge i_wr_clk)
   begin
      if (do_wr)
      begin
         mem_q[wbin_q[AW-1:0]] <= i_wr_data;
      end
   end
   always_ff @(posedge i_wr_clk or posedge i_wr_rst)
   begin
      if (i_wr_rst)
      begin
         wbin_q <= '0;
         wgray_q <= '0;
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end
      else
      begin
         wbin_q <= wbin_d;
         wgray_q <= bin2gray(wbin_d);
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
      end
   end
   always_ff @(posedge i_rd_clk or posedge i_rd_rst)
   begin
      if (i_rd_rst)
      begin
         rbin_q <= '0;
         rgray_q <= '0;
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end
      else
      begin
         rbin_q <= rbin_d;
         rgray_q <= bin2gray(rbin_d);
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
      end
   end
endmodule : flash_async_fifo

module nor_flash_operation_core #(
   parameter bit TOP_PARAM = 1'b0,
   // arbitrary neutral identifier value
   parameter logic [63:0] DEVICE_UID = 64'h0123_4567_89AB_CDEF
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire nor_flash_pkg::cmd_req_t i_cmd,
   input wire logic i_rd_valid,
   input wire logic [nor_flash_pkg::ADDR_W-1:0] i_rd_addr,
   output logic o_rd_valid,
   output logic [nor_flash_pkg::WORD_W-1:0] o_rd_data,
   output logic o_busy,
   input wire logic i_burst_clk,
   input wire logic i_burst_ack,
   output logic o_burst_wait,
   output logic [nor_flash_pkg::WORD_W-1:0] o_burst_data
);
   typedef enum {SEQ_IDLE, SEQ_PROG, SEQ_PSUSP, SEQ_ERASE, SEQ_ESUSP, SEQ_ESPROG} seq_t;
   typedef enum {RS_ARRAY, RS_STATUS, RS_ID} rd_src_t;
   localparam int AW = nor_flash_pkg::ADDR_W;
   localparam int DW = nor_flash_pkg::WORD_W;
   localparam int BW = nor_flash_pkg::BLK_W;
   localparam int CW = nor_flash_pkg::CNT_W;
   localparam int NB = nor_flash_pkg::NUM_PARAM + nor_flash_pkg::NUM_MAIN;
   localparam int PROG_BOUND = nor_flash_pkg::PROG_CYC + 2;
   seq_t state_q;
   rd_src_t rd_src_q;
   logic [DW-1:0] mem_q [nor_flash_pkg::ARRAY_WORDS];
   logic [DW-1:0] cfg_q, p_data_q, status;
   logic [AW-1:0] p_addr_q, e_addr_q, b_addr_q;
   logic [BW-1:0] e_blk_q, cmd_blk;
   logic [CW-1:0] p_cnt_q, e_cnt_q;
   logic [NB-1:0] lock_q;
   logic [nor_flash_pkg::NUM_OTP-1:0] otp_q;
   logic [7:0] b_left_q;
   logic perr_q, eerr_q, lerr_q, b_active_q, sync_mode;
   logic is_op, cmd_locked, cmd_otp, prog_blocked, prog_ok, prog_refuse, erase_ok, erase_refuse;
   logic prog_start, erase_start, prog_done, erase_done, suspend, resume, burst_go;
   logic fifo_wr_ready, fifo_rd_valid, fifo_rd_ready, out_valid_q, lrst_s1_q, lrst_q;
   logic [DW-1:0] fifo_rd_data;
   // ************************************************
   // block decode
   // ************************************************
   function automatic logic [BW-1:0] block_of(input logic [AW-1:0] a);
      int ai;
      ai = int'(a);
      if (!TOP_PARAM)
      begin
         if (ai < nor_flash_pkg::PARAM_SPAN)
            return BW'(ai / nor_flash_pkg::PARAM_WORDS);
         return BW'(nor_flash_pkg::NUM_PARAM + (ai - nor_flash_pkg::PARAM_SPAN) / nor_flash_pkg::MAIN_WORDS);
      end
      if (ai < nor_flash_pkg::MAIN_SPAN)
         return BW'(ai / nor_flash_pkg::MAIN_WORDS);
      return BW'(nor_flash_pkg::NUM_MAIN + (ai - nor_flash_pkg::MAIN_SPAN) / nor_flash_pkg::PARAM_WORDS);
   endfunction : block_of
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
      return (int'(a) == nor_flash_pkg::ARRAY_WORDS - 1) ? '0 : a + AW'(1);
   endfunction : next_addr
   // ************************************************
   // command decode
   // ************************************************
   assign cmd_blk = block_of(i_cmd.addr);
   assign cmd_locked = lock_q[cmd_blk];
   // regions are the four lowest numbered blocks; once marked, no erase and one program per word
   assign cmd_otp = (int'(cmd_blk) < nor_flash_pkg::NUM_OTP) && otp_q[cmd_blk[1:0]];
   assign prog_blocked = cmd_locked || (cmd_otp && mem_q[i_cmd.addr] != nor_flash_pkg::ERASED_WORD);
   always_comb
   begin
      is_op = i_cmd_valid;
      prog_ok = 1'b0;
      prog_refuse = 1'b0;
      erase_ok = 1'b0;
      erase_refuse = 1'b0;
      if (is_op && i_cmd.op == nor_flash_pkg::OP_PROGRAM)
      begin
         if (state_q == SEQ_IDLE || (state_q == SEQ_ESUSP && cmd_blk != e_blk_q))
         begin
            prog_ok = !prog_blocked;
            prog_refuse = prog_blocked;
         end
         else if (state_q == SEQ_ESUSP)
            prog_refuse = 1'b1;
      end
      if (is_op && i_cmd.op == nor_flash_pkg::OP_ERASE && state_q == SEQ_IDLE)
      begin
         erase_ok = !cmd_locked && !cmd_otp;
         erase_refuse = cmd_locked || cmd_otp;
      end
   end
   assign prog_start = prog_ok;
   assign erase_start = erase_ok;
   assign suspend = is_op && i_cmd.op == nor_flash_pkg::OP_SUSPEND;
   assign resume = is_op && i_cmd.op == nor_flash_pkg::OP_RESUME;
   assign prog_done = (state_q == SEQ_PROG || state_q == SEQ_ESPROG) && p_cnt_q == '0;
   assign erase_done = state_q == SEQ_ERASE && e_cnt_q == '0;
   assign sync_mode = !cfg_q[nor_flash_pkg::CFG_ASYNC_BIT];
   assign burst_go = is_op && i_cmd.op == nor_flash_pkg::OP_BURST && sync_mode && !b_active_q;
   // ************************************************
   // erase and program sequencer
   // ************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         state_q <= SEQ_IDLE;
      else
      begin
         case (state_q)
            SEQ_IDLE:
               if (prog_start)
                  state_q <= SEQ_PROG;
               else if (erase_start)
                  state_q <= SEQ_ERASE;
            SEQ_PROG:
               if (prog_done)
                  state_q <= SEQ_IDLE;
               else if (suspend)
                  state_q <= SEQ_PSUSP;
            SEQ_PSUSP:
               if (resume)
                  state_q <= SEQ_PROG;
            SEQ_ERASE:
               if (erase_done)
                  state_q <= SEQ_IDLE;
               else if (suspend)
                  state_q <= SEQ_ESUSP;
            SEQ_ESUSP:
               if (resume)
                  state_q <= SEQ_ERASE;
               else if (prog_start)
                  state_q <= SEQ_ESPROG;
            SEQ_ESPROG:
               if (prog_done)
                  state_q <= SEQ_ESUSP;
            default:
               state_q <= SEQ_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         p_cnt_q <= '0;
         p_addr_q <= '0;
         p_data_q <= '0;
      end
      else if (prog_start)
      begin
         p_cnt_q <= CW'(nor_flash_pkg::PROG_CYC - 1);
         p_addr_q <= i_cmd.addr;
         p_data_q <= i_cmd.data;
      end
      else if ((state_q == SEQ_PROG || state_q == SEQ_ESPROG) && p_cnt_q != '0)
         p_cnt_q <= p_cnt_q - CW'(1);
   end
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         e_cnt_q <= '0;
         e_blk_q <= '0;
         e_addr_q <= '0;
      end
      else if (erase_start)
      begin
         e_cnt_q <= CW'(nor_flash_pkg::ERASE_CYC - 1);
         e_blk_q <= cmd_blk;
         e_addr_q <= i_cmd.addr;
      end
      else if (state_q == SEQ_ERASE && e_cnt_q != '0)
         e_cnt_q <= e_cnt_q - CW'(1);
   end
   // ************************************************
   // array storage
   // ************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < nor_flash_pkg::ARRAY_WORDS; i++)
            mem_q[i] <= nor_flash_pkg::ERASED_WORD;
      end
      else if (prog_done)
         mem_q[p_addr_q] <= mem_q[p_addr_q] & p_data_q;
      else if (erase_done)
      begin
         for (int i = 0; i < nor_flash_pkg::ARRAY_WORDS; i++)
            if (block_of(AW'(i)) == e_blk_q)
               mem_q[i] <= nor_flash_pkg::ERASED_WORD;
      end
   end
   // ************************************************
   // lock, otp, configuration, sticky errors
   // ************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lock_q <= '1;
         otp_q <= '0;
         cfg_q <= nor_flash_pkg::CFG_RESET;
      end
      else if (is_op)
      begin
         if (i_cmd.op == nor_flash_pkg::OP_LOCK)
            lock_q[cmd_blk] <= 1'b1;
         if (i_cmd.op == nor_flash_pkg::OP_UNLOCK)
            lock_q[cmd_blk] <= 1'b0;
         if (i_cmd.op == nor_flash_pkg::OP_SET_OTP)
            otp_q[i_cmd.data[1:0]] <= 1'b1;
         if (i_cmd.op == nor_flash_pkg::OP_SET_CONFIG)
            cfg_q <= i_cmd.data;
      end
   end
   // set beats clear when both land in one cycle
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         perr_q <= 1'b0;
         eerr_q <= 1'b0;
         lerr_q <= 1'b0;
      end
      else
      begin
         perr_q <= prog_refuse || (perr_q && !(is_op && i_cmd.op == nor_flash_pkg::OP_CLEAR_STATUS));
         eerr_q <= erase_refuse || (eerr_q && !(is_op && i_cmd.op == nor_flash_pkg::OP_CLEAR_STATUS));
         lerr_q <= ((prog_refuse || erase_refuse) && cmd_locked)
            || (lerr_q && !(is_op && i_cmd.op == nor_flash_pkg::OP_CLEAR_STATUS));
      end
   end
   always_comb
   begin
      status = '0;
      status[nor_flash_pkg::ST_READY] = !o_busy;
      status[nor_flash_pkg::ST_ESUSP] = state_q == SEQ_ESUSP || state_q == SEQ_ESPROG;
      status[nor_flash_pkg::ST_PSUSP] = state_q == SEQ_PSUSP;
      status[nor_flash_pkg::ST_EERR] = eerr_q;
      status[nor_flash_pkg::ST_PERR] = perr_q;
      status[nor_flash_pkg::ST_LOCKERR] = lerr_q;
   end
   assign o_busy = state_q == SEQ_PROG || state_q == SEQ_ERASE || state_q == SEQ_ESPROG;
   // ************************************************
   // asynchronous read port
   // ************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         rd_src_q <= RS_ARRAY;
      else if (prog_start || erase_start)
         rd_src_q <= RS_STATUS;
      else if (is_op && i_cmd.op == nor_flash_pkg::OP_READ_ARRAY)
         rd_src_q <= RS_ARRAY;
      else if (is_op && i_cmd.op == nor_flash_pkg::OP_READ_STATUS)
         rd_src_q <= RS_STATUS;
      else if (is_op && i_cmd.op == nor_flash_pkg::OP_READ_ID)
         rd_src_q <= RS_ID;
   end
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end
      else
      begin
         o_rd_valid <= i_rd_valid;
         if (i_rd_valid)
         begin
            case (rd_src_q)
               RS_STATUS: o_rd_data <= status;
               RS_ID: o_rd_data <= DEVICE_UID[DW*i_rd_addr[1:0] +: DW];
               default: o_rd_data <= mem_q[i_rd_addr];
            endcase
         end
      end
   end
   // ************************************************
   // burst fill engine and link side
   // ************************************************
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         b_active_q <= 1'b0;
         b_addr_q <= '0;
         b_left_q <= '0;
      end
      else if (burst_go)
      begin
         b_active_q <= i_cmd.data[7:0] != '0;
         b_addr_q <= i_cmd.addr;
         b_left_q <= i_cmd.data[7:0];
      end
      else if (b_active_q && fifo_wr_ready)
      begin
         b_addr_q <= next_addr(b_addr_q);
         b_left_q <= b_left_q - 8'h01;
         b_active_q <= b_left_q != 8'h01;
      end
   end
   // reset released into the link domain so a stopped burst clock never sees a half reset
   always_ff @(posedge i_burst_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lrst_s1_q <= 1'b1;
         lrst_q <= 1'b1;
      end
      else
      begin
         lrst_s1_q <= 1'b0;
         lrst_q <= lrst_s1_q;
      end
   end
   flash_async_fifo #(.WIDTH(DW), .DEPTH(nor_flash_pkg::FIFO_DEPTH)) u_fifo (
      .i_wr_clk(i_ref_clk),
      .i_wr_rst(i_rst),
      .i_wr_valid(b_active_q),
      .i_wr_data(mem_q[b_addr_q]),
      .o_wr_ready(fifo_wr_ready),
      .i_rd_clk(i_burst_clk),
      .i_rd_rst(lrst_q),
      .o_rd_valid(fifo_rd_valid),
      .o_rd_data(fifo_rd_data),
      .i_rd_ready(fifo_rd_ready)
   );
   assign fifo_rd_ready = !out_valid_q || i_burst_ack;
   always_ff @(posedge i_burst_clk or posedge lrst_q)
   begin
      if (lrst_q)
      begin
         out_valid_q <= 1'b0;
         o_burst_data <= '0;
      end
      else if (fifo_rd_ready)
      begin
         out_valid_q <= fifo_rd_valid;
         o_burst_data <= fifo_rd_data;
      end
   end
   assign o_burst_wait = !out_valid_q;
   // ************************************************
   // assertions
   // ************************************************
   AST_ASYNC_HOLDS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!sync_mode && !(is_op && i_cmd.op == nor_flash_pkg::OP_SET_CONFIG)) |=> !sync_mode)
      else $error("read mode left async without a config write");
   AST_NO_ASYNC_BURST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!b_active_q && !sync_mode) |=> !b_active_q)
      else $error("burst started in async mode");
   AST_BURST_DATA_HELD: assert property (@(posedge i_burst_clk) disable iff (lrst_q)
      (!o_burst_wait && !i_burst_ack) |=> ($stable(o_burst_data) && !o_burst_wait))
      else $error("burst word changed before it was taken");
   AST_WAIT_EMPTY: assert property (@(posedge i_burst_clk) disable iff (lrst_q)
      (o_burst_wait && !fifo_rd_valid) |=> o_burst_wait)
      else $error("wait dropped with no word available");
   AST_ERASE_CLEARS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      erase_done |=> mem_q[e_addr_q] == nor_flash_pkg::ERASED_WORD)
      else $error("erased block word not blank");
   AST_PROG_TIMED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == SEQ_IDLE && prog_start) |=> o_busy ##[1:PROG_BOUND] !o_busy)
      else $error("program did not finish in time");
   AST_LOCK_REFUSE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == SEQ_IDLE && is_op && i_cmd.op == nor_flash_pkg::OP_PROGRAM && cmd_locked)
      |=> (perr_q && lerr_q && state_q == SEQ_IDLE))
      else $error("program to locked block not flagged");
   AST_ERASE_SUSPEND: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == SEQ_ERASE && !erase_done && suspend) |=> (state_q == SEQ_ESUSP && !o_busy))
      else $error("erase did not suspend");
   AST_PROG_SUSPEND: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == SEQ_PROG && !prog_done && suspend) |=> (state_q == SEQ_PSUSP) ##1 $stable(p_cnt_q))
      else $error("program did not suspend");
   AST_PROG_WORD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      prog_done |=> mem_q[$past(p_addr_q)] == ($past(mem_q[p_addr_q]) & $past(p_data_q)))
      else $error("programmed word wrong");
   AST_LOCK_NOW: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (is_op && i_cmd.op == nor_flash_pkg::OP_UNLOCK) |=> !lock_q[$past(cmd_blk)])
      else $error("unlock not immediate");
   AST_OTP_ERASE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == SEQ_IDLE && is_op && i_cmd.op == nor_flash_pkg::OP_ERASE && cmd_otp) |=> eerr_q)
      else $error("otp region erase not refused");
   AST_BUSY_STATUS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_busy |-> !status[nor_flash_pkg::ST_READY])
      else $error("ready shown while busy");
   COV_BURST: cover property (@(posedge i_burst_clk) disable iff (lrst_q) !o_burst_wait && i_burst_ack);
   COV_ESUSP_PROG: cover property (@(posedge i_ref_clk) disable iff (i_rst) state_q == SEQ_ESPROG && prog_done);
   COV_ERASE: cover property (@(posedge i_ref_clk) disable iff (i_rst) erase_done);
endmodule : nor_flash_operation_core
`default_nettype wire

// File: nor_flash_pkg.sv
/*
 shared constants, enums and carriers of the nor flash operation core.
 assumes a 20 MHz core clock and a host on the same clock for commands and reads.
*/
`default_nettype none
package nor_flash_pkg;
   // ************************************************
   // geometry, scaled array held in flip-flops
   // ************************************************
   localparam int WORD_W = 16;
   localparam int ADDR_W = 6;
   localparam int BLK_W = 3;
   localparam int NUM_PARAM = 4;
   localparam int NUM_MAIN = 4;
   localparam int PARAM_WORDS = 2;
   localparam int MAIN_WORDS = 8;
   localparam int PARAM_SPAN = NUM_PARAM * PARAM_WORDS;
   localparam int MAIN_SPAN = NUM_MAIN * MAIN_WORDS;
   localparam int ARRAY_WORDS = PARAM_SPAN + MAIN_SPAN;
   localparam int NUM_OTP = 4;
   localparam int UID_WORDS = 4;
   localparam int FIFO_DEPTH = 32;
   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
   // ************************************************
   // read mode configuration and status layout
   // ************************************************
   localparam logic [WORD_W-1:0] CFG_RESET = 16'h8000;
   localparam int CFG_ASYNC_BIT = 15;
   localparam int ST_READY = 7;
   localparam int ST_ESUSP = 6;
   localparam int ST_EERR = 5;
   localparam int ST_PERR = 4;
   localparam int ST_PSUSP = 2;
   localparam int ST_LOCKERR = 1;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_MHZ = 20;
   localparam int PROG_TIME_NS = 10000;
   localparam int ERASE_TIME_NS = 100000;
   localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 12;
   // ************************************************
   // commands and carriers
   // ************************************************
   typedef enum logic [3:0] {
      OP_READ_ARRAY, OP_READ_STATUS, OP_READ_ID, OP_CLEAR_STATUS, OP_PROGRAM, OP_ERASE,
      OP_SUSPEND, OP_RESUME, OP_LOCK, OP_UNLOCK, OP_SET_CONFIG, OP_SET_OTP, OP_BURST
   } cmd_op_t;
   typedef struct packed {
      cmd_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } cmd_req_t;
endpackage : nor_flash_pkg
`default_nettype wire

// File: tb_top.sv
/*
 bench for the flash core: commands, reads, erase, burst.
 assumes the host model makes the link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_v = 1'b0;
   nor_flash_pkg::cmd_req_t cmd = '0;
   logic rd_v = 1'b0;
   logic [5:0] rd_a = 6'h00;
   logic rd_ok, busy, bclk, ack, bwait, b_en = 1'b1;
   logic [15:0] rd_d, bdata;
   int fails = 0;
   int n_checks = 0;
   // arbitrary identifier value
   localparam logic [63:0] UID = 64'h1357_9BDF_2468_ACE0;
   always #25 ref_clk = ~ref_clk;
   nor_flash_operation_core #(.DEVICE_UID(UID)) uut (.i_ref_clk(ref_clk), .i_rst(rst), .i_cmd_valid(cmd_v),
      .i_cmd(cmd), .i_rd_valid(rd_v), .i_rd_addr(rd_a), .o_rd_valid(rd_ok), .o_rd_data(rd_d), .o_busy(busy),
      .i_burst_clk(bclk), .i_burst_ack(ack), .o_burst_wait(bwait), .o_burst_data(bdata));
   burst_host_model host (.i_en(b_en), .i_wait(bwait), .i_data(bdata), .o_clk(bclk), .o_ack(ack));
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic final_report;
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic issue(input nor_flash_pkg::cmd_op_t op, input logic [5:0] a, input logic [15:0] dt);
      @(posedge ref_clk);
      cmd_v <= 1'b1;
      cmd <= '{op, a, dt};
      @(posedge ref_clk);
      cmd_v <= 1'b0;
   endtask : issue
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      rd_v <= 1'b1;
      rd_a <= a;
      @(posedge ref_clk);
      rd_v <= 1'b0;
      #1;
      if (rd_ok !== 1'b1) @(posedge ref_clk) #1;
      chk(rd_ok, 16'h1);
      chk(rd_d, exp);
   endtask : rd
   // busy must last a real operation, and a hang is cut short
   task automatic run(input nor_flash_pkg::cmd_op_t op, input logic [5:0] a, input logic [15:0] dt, input int cyc);
      int n;
      issue(op, a, dt);
      for (n = 0; n < 3000; n++)
      begin
         #1;
         if (busy !== 1'b1) break;
         @(posedge ref_clk);
      end
      chk(16'(n), 16'(cyc));
      if (n == 3000) final_report();
   endtask : run
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset;
      chk(busy, 1'b0);
      chk(bwait, 1'b1);
      issue(nor_flash_pkg::OP_READ_STATUS, 6'h00, 16'h0000);
      rd(6'h00, 16'h0080);
      issue(nor_flash_pkg::OP_READ_ID, 6'h00, 16'h0000);
      rd(6'h01, UID[31:16]);
   endtask : t_reset
   task automatic t_lock_prog;
      issue(nor_flash_pkg::OP_PROGRAM, 6'h09, 16'h1234);
      issue(nor_flash_pkg::OP_READ_STATUS, 6'h00, 16'h0000);
      rd(6'h00, 16'h0092);
      issue(nor_flash_pkg::OP_CLEAR_STATUS, 6'h00, 16'h0000);
      issue(nor_flash_pkg::OP_UNLOCK, 6'h09, 16'h0000);
      issue(nor_flash_pkg::OP_UNLOCK, 6'h10, 16'h0000);
      run(nor_flash_pkg::OP_PROGRAM, 6'h09, 16'h1234, nor_flash_pkg::PROG_CYC);
      run(nor_flash_pkg::OP_PROGRAM, 6'h10, 16'hABCD, nor_flash_pkg::PROG_CYC);
      rd(6'h00, 16'h0080);
      issue(nor_flash_pkg::OP_READ_ARRAY, 6'h00, 16'h0000);
      rd(6'h09, 16'h1234);
      rd(6'h08, 16'hFFFF);
   endtask : t_lock_prog
   task automatic t_burst;
      int k;
      b_en <= 1'b1;
      issue(nor_flash_pkg::OP_BURST, 6'h08, 16'h0009);
      repeat (40) @(posedge ref_clk);
      chk(16'(host.got.size()), 16'h0);
      issue(nor_flash_pkg::OP_SET_CONFIG, 6'h00, 16'h0000);
      issue(nor_flash_pkg::OP_BURST, 6'h08, 16'h0009);
      for (k = 0; k < 400 && host.got.size() < 9; k++) @(posedge ref_clk);
      chk(16'(host.got.size()), 16'h9);
      if (k == 400) final_report();
      chk(host.got[0], 16'hFFFF);
      chk(host.got[1], 16'h1234);
      chk(host.got[8], 16'hABCD);
      b_en <= 1'b0;
   endtask : t_burst
   task automatic t_erase;
      run(nor_flash_pkg::OP_ERASE, 6'h0C, 16'h0000, nor_flash_pkg::ERASE_CYC);
      issue(nor_flash_pkg::OP_READ_ARRAY, 6'h00, 16'h0000);
      rd(6'h09, 16'hFFFF);
      rd(6'h10, 16'hABCD);
   endtask : t_erase
   // suspended erase counts 22 cycles before the pause, program 2
   task automatic t_suspend;
      issue(nor_flash_pkg::OP_ERASE, 6'h10, 16'h0000);
      repeat (20) @(posedge ref_clk);
      issue(nor_flash_pkg::OP_SUSPEND, 6'h00, 16'h0000);
      rd(6'h00, 16'h00C0);
      run(nor_flash_pkg::OP_PROGRAM, 6'h09, 16'h5555, nor_flash_pkg::PROG_CYC);
      issue(nor_flash_pkg::OP_READ_ARRAY, 6'h00, 16'h0000);
      rd(6'h10, 16'hABCD);
      run(nor_flash_pkg::OP_RESUME, 6'h00, 16'h0000, nor_flash_pkg::ERASE_CYC - 22);
      issue(nor_flash_pkg::OP_READ_ARRAY, 6'h00, 16'h0000);
      rd(6'h10, 16'hFFFF);
      rd(6'h09, 16'h5555);
      issue(nor_flash_pkg::OP_PROGRAM, 6'h11, 16'h00FF);
      issue(nor_flash_pkg::OP_SUSPEND, 6'h00, 16'h0000);
      rd(6'h00, 16'h0084);
      run(nor_flash_pkg::OP_RESUME, 6'h00, 16'h0000, nor_flash_pkg::PROG_CYC - 2);
      issue(nor_flash_pkg::OP_READ_ARRAY, 6'h00, 16'h0000);
      rd(6'h11, 16'h00FF);
      issue(nor_flash_pkg::OP_LOCK, 6'h11, 16'h0000);
      issue(nor_flash_pkg::OP_ERASE, 6'h11, 16'h0000);
      issue(nor_flash_pkg::OP_READ_STATUS, 6'h00, 16'h0000);
      rd(6'h00, 16'h00A2);
   endtask : t_suspend
   // a second reset must drop burst mode and read the array again
   task automatic t_rereset;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(6'h11, 16'hFFFF);
      b_en <= 1'b1;
      issue(nor_flash_pkg::OP_BURST, 6'h08, 16'h0001);
      repeat (40) @(posedge ref_clk);
      chk(16'(host.got.size()), 16'h9);
   endtask : t_rereset
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      b_en <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_lock_prog();
      t_burst();
      t_erase();
      t_suspend();
      t_rereset();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
